// ### pin_mux_pkg.sv
// shared constants and types for the host connector pin control
package pin_mux_pkg;

	// ==========================================================
	// connector pin positions
	localparam int PIN_COUNT = 28;
	localparam int PIN_PCLK = 0;
	localparam int PIN_DE = 1;
	localparam int PIN_VSYNC = 2;
	localparam int PIN_HSYNC = 3;
	localparam int PIN_BLUE_LSB = 4;
	localparam int PIN_GREEN_LSB = 10;
	localparam int PIN_RED_LSB = 16;
	localparam int PIN_RED_MSB = 21;
	localparam int PIN_SCL = 22;
	localparam int PIN_SDA = 23;
	localparam int PIN_SEL_CTRL = 24;
	localparam int PIN_BUF_EN = 25;
	localparam int PIN_PWR = 26;
	localparam int PIN_SEL_LOGIC = 27;
	localparam int PIN_SPI_CS = 8;
	localparam int PIN_SPI_MISO = 9;
	localparam int PIN_SPI_MOSI = 10;
	localparam int PIN_SPI_SCLK = 11;

	// ==========================================================
	// colour format: six bits per colour, two low bits dropped
	localparam int COLOUR_BITS = 6;
	localparam int COLOUR_DROP = 2;
	localparam int COLOUR_IN_BITS = 8;

	// ==========================================================
	// modes and transition phases
	typedef enum logic [1:0] {
		MODE_NONE = 2'h0,
		MODE_VIDEO = 2'h1,
		MODE_CTRL_FLASH = 2'h2,
		MODE_LOGIC_FLASH = 2'h3
	} mode_e;

	typedef enum logic [1:0] {
		PH_INPUTS = 2'h0,
		PH_CONFIG = 2'h1,
		PH_ACTIVE = 2'h2
	} phase_e;

	// ==========================================================
	// register word addresses and fields
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_I2C = 3'h2;
	localparam logic [2:0] REG_SPI = 3'h3;
	localparam int CTRL_MODE_LSB = 0;
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_PHASE_LSB = 2;
	localparam int STAT_SPI_BUSY = 4;
	localparam int STAT_GAP_BUSY = 5;
	localparam int STAT_TARGET_LSB = 6;
	localparam int I2C_SCL_BIT = 0;
	localparam int I2C_SDA_BIT = 1;
	localparam int I2C_GAP_BIT = 2;
	localparam int SPI_HOLD_BIT = 8;
	localparam int SPI_BUSY_BIT = 8;

	// ==========================================================
	// timing
	localparam int SYS_CLK_MHZ = 250;
	localparam int I2C_GAP_MS = 600;
	localparam int I2C_GAP_CYCLES_DEF = I2C_GAP_MS * 1000 * SYS_CLK_MHZ;
	localparam int GAP_W = 28;
	localparam int SETTLE_CYCLES = 8;
	localparam int PCLK_HALF = 4;
	localparam int SPI_HALF = 32;
	localparam int SPI_BITS = 8;

endpackage

// ### pin_bus.sv
// connector wires between host and board, resolved from the drive enables
interface pin_bus;
	import pin_mux_pkg::*;

	logic [PIN_COUNT-1:0] host_out;
	logic [PIN_COUNT-1:0] host_oe_n;
	logic dev_miso;
	logic dev_miso_oe_n;
	logic [PIN_COUNT-1:0] pin_level;
	logic link_clk;

	// an undriven line settles low: power stays on, buffer and selects off
	genvar i;
	for (i = 0; i < PIN_COUNT; i++) begin : g_res
		if (i == PIN_SPI_MISO) begin : g_miso
			assign pin_level[i] = !host_oe_n[i] ? host_out[i] : (!dev_miso_oe_n ? dev_miso : 1'b0);
		end else begin : g_pin
			assign pin_level[i] = !host_oe_n[i] ? host_out[i] : 1'b0;
		end
	end

	assign link_clk = pin_level[PIN_PCLK];

	modport host (output host_out, output host_oe_n, input pin_level);
	modport board (input pin_level, output dev_miso, output dev_miso_oe_n);
endinterface

// ### board_pin_receiver.sv
// board end of the host connector: video capture, command lines, flash spi slave
module board_pin_receiver (
	input wire logic link_clk,
	input wire logic reset_n,
	pin_bus.board pins,
	input wire logic [7:0] flash_reply,
	output logic [pin_mux_pkg::COLOUR_BITS-1:0] pixel_red,
	output logic [pin_mux_pkg::COLOUR_BITS-1:0] pixel_green,
	output logic [pin_mux_pkg::COLOUR_BITS-1:0] pixel_blue,
	output logic pixel_data_valid,
	output logic pixel_vsync,
	output logic pixel_hsync,
	output logic i2c_scl,
	output logic i2c_sda,
	output logic board_power_off,
	output logic flash_sel_ctrl,
	output logic flash_sel_logic,
	output logic [7:0] flash_byte,
	output logic flash_byte_valid,
	output logic select_fault
);
	import pin_mux_pkg::*;

	// ==========================================================
	// input synchronisers
	logic [PIN_COUNT-1:0] s1_r;
	logic [PIN_COUNT-1:0] s2_r;

	genvar i;
	for (i = 0; i < PIN_COUNT; i++) begin : g_sync
		always_ff @(posedge link_clk or negedge reset_n) begin
			if (!reset_n) begin
				s1_r[i] <= 1'b0;
				s2_r[i] <= 1'b0;
			end else begin
				s1_r[i] <= pins.pin_level[i];
				s2_r[i] <= s1_r[i];
			end
		end
	end

	// ==========================================================
	// video capture; enable and syncs gated by the buffer enable, colour bits not gated
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			pixel_red <= '0;
			pixel_green <= '0;
			pixel_blue <= '0;
			pixel_data_valid <= 1'b0;
			pixel_vsync <= 1'b0;
			pixel_hsync <= 1'b0;
		end else begin
			pixel_red <= s2_r[PIN_RED_LSB +: COLOUR_BITS]; // R2
			pixel_green <= s2_r[PIN_GREEN_LSB +: COLOUR_BITS]; // R2
			pixel_blue <= s2_r[PIN_BLUE_LSB +: COLOUR_BITS]; // R2
			pixel_data_valid <= s2_r[PIN_DE] && s2_r[PIN_BUF_EN]; // R5
			pixel_vsync <= s2_r[PIN_VSYNC] && s2_r[PIN_BUF_EN]; // R5
			pixel_hsync <= s2_r[PIN_HSYNC] && s2_r[PIN_BUF_EN]; // R5
		end
	end

	// ==========================================================
	// control lines and select interlock
	logic fault;
	assign fault = (s2_r[PIN_SEL_CTRL] && s2_r[PIN_SEL_LOGIC])
		|| (s2_r[PIN_BUF_EN] && (s2_r[PIN_SEL_CTRL] || s2_r[PIN_SEL_LOGIC])); // R8 R9

	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			i2c_scl <= 1'b1;
			i2c_sda <= 1'b1;
			board_power_off <= 1'b0;
			flash_sel_ctrl <= 1'b0;
			flash_sel_logic <= 1'b0;
			select_fault <= 1'b0;
		end else begin
			i2c_scl <= s2_r[PIN_SCL];
			i2c_sda <= s2_r[PIN_SDA];
			board_power_off <= s2_r[PIN_PWR]; // R6
			flash_sel_ctrl <= s2_r[PIN_SEL_CTRL] && !fault; // R7
			flash_sel_logic <= s2_r[PIN_SEL_LOGIC] && !fault; // R7
			select_fault <= fault;
		end
	end

	// ==========================================================
	// flash spi slave, mode 0, msb first
	logic spi_active;
	logic sclk_prev_r;
	logic [2:0] bit_r;
	logic [7:0] shift_in_r;
	logic [7:0] reply_r;
	logic miso_oe_n_r;

	// pixel lines share these pins, so the slave only listens with a select up
	assign spi_active = !s2_r[PIN_SPI_CS] && !fault
		&& (s2_r[PIN_SEL_CTRL] || s2_r[PIN_SEL_LOGIC]); // R7 R9

	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_prev_r <= 1'b0;
			bit_r <= '0;
			shift_in_r <= '0;
			reply_r <= '0;
			miso_oe_n_r <= 1'b1;
			flash_byte <= '0;
			flash_byte_valid <= 1'b0;
		end else begin
			sclk_prev_r <= s2_r[PIN_SPI_SCLK];
			flash_byte_valid <= 1'b0;
			miso_oe_n_r <= !spi_active;
			if (!spi_active) begin
				bit_r <= '0;
				reply_r <= flash_reply;
			end else if (s2_r[PIN_SPI_SCLK] && !sclk_prev_r) begin
				shift_in_r <= {shift_in_r[6:0], s2_r[PIN_SPI_MOSI]};
				bit_r <= bit_r + 3'h1;
				if (bit_r == 3'(SPI_BITS - 1)) begin
					flash_byte <= {shift_in_r[6:0], s2_r[PIN_SPI_MOSI]};
					flash_byte_valid <= 1'b1;
				end
			end else if (!s2_r[PIN_SPI_SCLK] && sclk_prev_r) begin
				reply_r <= (bit_r == 3'h0) ? flash_reply : {reply_r[6:0], 1'b0};
			end
		end
	end

	assign pins.dev_miso = reply_r[7];
	assign pins.dev_miso_oe_n = miso_oe_n_r;

endmodule

// ### host_mode_pin_control.sv
// host end of the connector: mode sequencer, video driver, i2c lines, flash spi master

// What this block does
// R1 - video mode drives clock, syncs, enable, colour
// R2 - six bits per colour, low two dropped
// R3 - i2c clock and data are plain outputs in video mode, inputs otherwise
// R4 - gap after flash-access i2c commands
// R5 - buffer enable high in active video, driven low during video config, floating otherwise
// R6 - power line high turns board off
// R7 - flash selects are active high
// R8 - never both flash selects high
// R9 - no spi or selects during video
// R10 - flash modes: spi pins, chip select, power high
// R11 - spi used only for flash writes
// R12 - only the chosen flash select is driven
// R13 - video config leaves power, selects as inputs
// R14 - all lines to inputs before any change
// R15 - inputs, configure, then enable; never both functions
module host_mode_pin_control #(
	parameter int unsigned I2C_GAP_CYCLES = pin_mux_pkg::I2C_GAP_CYCLES_DEF
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [pin_mux_pkg::COLOUR_IN_BITS-1:0] vid_red,
	input wire logic [pin_mux_pkg::COLOUR_IN_BITS-1:0] vid_green,
	input wire logic [pin_mux_pkg::COLOUR_IN_BITS-1:0] vid_blue,
	input wire logic vid_de,
	input wire logic vid_vsync,
	input wire logic vid_hsync,
	output logic vid_take,
	pin_bus.host pins
);
	import pin_mux_pkg::*;

	// ==========================================================
	// state
	mode_e mode_r;
	mode_e target_r;
	phase_e phase_r;
	logic [3:0] settle_r;
	logic waitrequest_r;
	logic [31:0] readdata_r;
	logic [1:0] div_r;
	logic pclk_r;
	logic [COLOUR_BITS-1:0] red_r;
	logic [COLOUR_BITS-1:0] green_r;
	logic [COLOUR_BITS-1:0] blue_r;
	logic de_r;
	logic vs_r;
	logic hs_r;
	logic vid_take_r;
	logic scl_r;
	logic sda_r;
	logic [GAP_W-1:0] gap_r;
	logic spi_busy_r;
	logic spi_hold_r;
	logic spi_cs_n_r;
	logic spi_sclk_r;
	logic spi_high_r;
	logic [4:0] spi_cnt_r;
	logic [2:0] spi_bit_r;
	logic [7:0] spi_tx_r;
	logic [7:0] spi_rx_r;
	logic miso_s1_r;
	logic miso_s2_r;
	logic [PIN_COUNT-1:0] pin_out_r;
	logic [PIN_COUNT-1:0] pin_oe_n_r;
	logic [PIN_COUNT-1:0] pin_out_nxt;
	logic [PIN_COUNT-1:0] pin_oe_n_nxt;

	logic video_on;
	logic flash_on;
	logic launch;
	logic acc_wr;
	logic ok;
	logic [31:0] rd_mux;

	assign video_on = (mode_r == MODE_VIDEO) && (phase_r == PH_ACTIVE);
	assign flash_on = (mode_r == MODE_CTRL_FLASH || mode_r == MODE_LOGIC_FLASH)
		&& (phase_r == PH_ACTIVE);
	assign launch = (div_r == 2'(PCLK_HALF - 1)) && pclk_r;
	assign acc_wr = avs_write && !waitrequest_r;

	// ==========================================================
	// avalon slave: registered waitrequest, one wait state minimum
	always_comb begin
		ok = 1'b1;
		if (avs_write) begin
			unique case (avs_address)
				REG_CTRL: ok = (phase_r == PH_ACTIVE) && !spi_busy_r;
				REG_I2C: ok = (gap_r == '0); // R4
				REG_SPI: ok = !spi_busy_r;
				default: ok = 1'b1;
			endcase
		end
	end

	always_comb begin
		rd_mux = '0;
		unique case (avs_address)
			REG_CTRL: rd_mux[CTRL_MODE_LSB +: 2] = target_r;
			REG_STATUS: begin
				rd_mux[STAT_MODE_LSB +: 2] = mode_r;
				rd_mux[STAT_PHASE_LSB +: 2] = phase_r;
				rd_mux[STAT_SPI_BUSY] = spi_busy_r;
				rd_mux[STAT_GAP_BUSY] = (gap_r != '0);
				rd_mux[STAT_TARGET_LSB +: 2] = target_r;
			end
			REG_I2C: begin
				rd_mux[I2C_SCL_BIT] = scl_r;
				rd_mux[I2C_SDA_BIT] = sda_r;
				rd_mux[I2C_GAP_BIT] = (gap_r != '0);
			end
			REG_SPI: begin
				rd_mux[7:0] = spi_rx_r;
				rd_mux[SPI_BUSY_BIT] = spi_busy_r;
			end
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			waitrequest_r <= 1'b1;
			readdata_r <= '0;
		end else if (!waitrequest_r) begin
			waitrequest_r <= 1'b1;
		end else if ((avs_read || avs_write) && ok) begin
			waitrequest_r <= 1'b0;
			readdata_r <= rd_mux;
		end
	end

	// ==========================================================
	// mode sequencer: every change passes through all-inputs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_r <= MODE_NONE;
			target_r <= MODE_NONE;
			phase_r <= PH_ACTIVE;
			settle_r <= '0;
		end else if (acc_wr && avs_address == REG_CTRL) begin
			target_r <= mode_e'(avs_writedata[CTRL_MODE_LSB +: 2]);
			mode_r <= MODE_NONE; // R14
			phase_r <= PH_INPUTS; // R14
			settle_r <= '0;
		end else if (phase_r != PH_ACTIVE) begin
			settle_r <= settle_r + 4'h1;
			if (settle_r == 4'(SETTLE_CYCLES - 1)) begin
				settle_r <= '0;
				if (phase_r == PH_CONFIG || target_r == MODE_NONE) begin
					phase_r <= PH_ACTIVE; // R15
				end else begin
					mode_r <= target_r; // R15
					phase_r <= PH_CONFIG; // R15
				end
			end
		end
	end

	// ==========================================================
	// pixel clock divider and video launch on the falling edge
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_r <= '0;
			pclk_r <= 1'b0;
		end else if (div_r == 2'(PCLK_HALF - 1)) begin
			div_r <= '0;
			pclk_r <= !pclk_r;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			red_r <= '0;
			green_r <= '0;
			blue_r <= '0;
			de_r <= 1'b0;
			vs_r <= 1'b0;
			hs_r <= 1'b0;
			vid_take_r <= 1'b0;
		end else begin
			vid_take_r <= launch && video_on;
			if (!video_on) begin
				red_r <= '0;
				green_r <= '0;
				blue_r <= '0;
				de_r <= 1'b0;
				vs_r <= 1'b0;
				hs_r <= 1'b0;
			end else if (launch) begin
				red_r <= vid_red[COLOUR_IN_BITS-1:COLOUR_DROP]; // R2
				green_r <= vid_green[COLOUR_IN_BITS-1:COLOUR_DROP]; // R2
				blue_r <= vid_blue[COLOUR_IN_BITS-1:COLOUR_DROP]; // R2
				de_r <= vid_de;
				vs_r <= vid_vsync;
				hs_r <= vid_hsync;
			end
		end
	end

	// ==========================================================
	// software i2c lines and the post-flash-command gap
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			gap_r <= '0;
		end else if (acc_wr && avs_address == REG_I2C) begin
			scl_r <= avs_writedata[I2C_SCL_BIT]; // R3
			sda_r <= avs_writedata[I2C_SDA_BIT]; // R3
			if (avs_writedata[I2C_GAP_BIT]) begin
				gap_r <= GAP_W'(I2C_GAP_CYCLES); // R4
			end
		end else if (gap_r != '0) begin
			gap_r <= gap_r - GAP_W'(1);
		end
	end

	// ==========================================================
	// flash spi master, mode 0, msb first; writes outside flash mode are dropped
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			miso_s1_r <= 1'b0;
			miso_s2_r <= 1'b0;
		end else begin
			miso_s1_r <= pins.pin_level[PIN_SPI_MISO];
			miso_s2_r <= miso_s1_r;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			spi_busy_r <= 1'b0;
			spi_hold_r <= 1'b0;
			spi_cs_n_r <= 1'b1;
			spi_sclk_r <= 1'b0;
			spi_high_r <= 1'b0;
			spi_cnt_r <= '0;
			spi_bit_r <= '0;
			spi_tx_r <= '0;
			spi_rx_r <= '0;
		end else if (!flash_on) begin
			spi_busy_r <= 1'b0; // R11
			spi_cs_n_r <= 1'b1; // R11
			spi_sclk_r <= 1'b0;
		end else if (acc_wr && avs_address == REG_SPI) begin
			spi_busy_r <= 1'b1;
			spi_hold_r <= avs_writedata[SPI_HOLD_BIT];
			spi_tx_r <= avs_writedata[7:0];
			spi_cs_n_r <= 1'b0;
			spi_sclk_r <= 1'b0;
			spi_high_r <= 1'b0;
			spi_cnt_r <= '0;
			spi_bit_r <= '0;
		end else if (spi_busy_r) begin
			spi_cnt_r <= spi_cnt_r + 5'h1;
			if (spi_cnt_r == 5'(SPI_HALF - 1)) begin
				spi_cnt_r <= '0;
				spi_high_r <= !spi_high_r;
				spi_sclk_r <= !spi_high_r;
				if (!spi_high_r) begin
					spi_rx_r <= {spi_rx_r[6:0], miso_s2_r};
				end else begin
					spi_tx_r <= {spi_tx_r[6:0], 1'b0};
					spi_bit_r <= spi_bit_r + 3'h1;
					if (spi_bit_r == 3'(SPI_BITS - 1)) begin
						spi_busy_r <= 1'b0;
						spi_cs_n_r <= !spi_hold_r;
					end
				end
			end
		end
	end

	// ==========================================================
	// pin map: one mode at a time, so video and spi never overlap
	always_comb begin
		pin_out_nxt = '0;
		pin_oe_n_nxt = '1;
		unique case (mode_r)
			MODE_NONE: begin
			end
			MODE_VIDEO: begin
				for (int k = PIN_PCLK; k <= PIN_RED_MSB; k++) begin
					pin_oe_n_nxt[k] = 1'b0; // R1
				end
				pin_out_nxt[PIN_PCLK] = pclk_r; // R1
				pin_out_nxt[PIN_DE] = de_r; // R1
				pin_out_nxt[PIN_VSYNC] = vs_r; // R1
				pin_out_nxt[PIN_HSYNC] = hs_r; // R1
				pin_out_nxt[PIN_RED_LSB +: COLOUR_BITS] = red_r; // R2
				pin_out_nxt[PIN_GREEN_LSB +: COLOUR_BITS] = green_r; // R2
				pin_out_nxt[PIN_BLUE_LSB +: COLOUR_BITS] = blue_r; // R2
				pin_oe_n_nxt[PIN_SCL] = 1'b0; // R3
				pin_oe_n_nxt[PIN_SDA] = 1'b0; // R3
				pin_out_nxt[PIN_SCL] = scl_r;
				pin_out_nxt[PIN_SDA] = sda_r;
				pin_oe_n_nxt[PIN_BUF_EN] = 1'b0; // R5
				pin_out_nxt[PIN_BUF_EN] = (phase_r == PH_ACTIVE); // R5 R15
				// power and both selects stay inputs here
			end
			MODE_CTRL_FLASH, MODE_LOGIC_FLASH: begin
				pin_oe_n_nxt[PIN_PCLK] = 1'b0;
				pin_out_nxt[PIN_PCLK] = pclk_r;
				pin_oe_n_nxt[PIN_SPI_CS] = 1'b0; // R10
				pin_out_nxt[PIN_SPI_CS] = spi_cs_n_r; // R10
				pin_oe_n_nxt[PIN_SPI_MOSI] = 1'b0; // R10
				pin_out_nxt[PIN_SPI_MOSI] = spi_tx_r[7];
				pin_oe_n_nxt[PIN_SPI_SCLK] = 1'b0; // R10
				pin_out_nxt[PIN_SPI_SCLK] = spi_sclk_r;
				pin_oe_n_nxt[PIN_PWR] = 1'b0; // R10
				pin_out_nxt[PIN_PWR] = 1'b1; // R6 R10
				if (mode_r == MODE_CTRL_FLASH) begin
					pin_oe_n_nxt[PIN_SEL_CTRL] = 1'b0; // R12
					pin_out_nxt[PIN_SEL_CTRL] = (phase_r == PH_ACTIVE); // R7 R8
				end else begin
					pin_oe_n_nxt[PIN_SEL_LOGIC] = 1'b0; // R12
					pin_out_nxt[PIN_SEL_LOGIC] = (phase_r == PH_ACTIVE); // R7 R8
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_out_r <= '0;
			pin_oe_n_r <= '1; // R14
		end else begin
			pin_out_r <= pin_out_nxt;
			pin_oe_n_r <= pin_oe_n_nxt; // R9 R13
		end
	end

	assign pins.host_out = pin_out_r;
	assign pins.host_oe_n = pin_oe_n_r;
	assign avs_waitrequest = waitrequest_r;
	assign avs_readdata = readdata_r;
	assign vid_take = vid_take_r;

endmodule

// ### host_mode_pin_control_properties.sv
// concurrent checks on the connector wires between host and board
module host_mode_pin_control_properties (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [pin_mux_pkg::PIN_COUNT-1:0] host_out,
	input wire logic [pin_mux_pkg::PIN_COUNT-1:0] host_oe_n,
	input wire logic [pin_mux_pkg::PIN_COUNT-1:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	import pin_mux_pkg::*;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// helper: how long the host has left every line undriven
	logic all_in;
	logic [3:0] in_cnt_r;
	assign all_in = &host_oe_n;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			in_cnt_r <= 4'h0;
		end else if (!all_in) begin
			in_cnt_r <= 4'h0;
		end else if (in_cnt_r != 4'hf) begin
			in_cnt_r <= in_cnt_r + 4'h1;
		end
	end

	sequence s_leave_inputs;
		all_in ##1 !all_in;
	endsequence
	sequence s_flash_cfg;
		host_oe_n[PIN_BUF_EN] && !host_oe_n[PIN_SPI_CS];
	endsequence

	// ==========================================================
	// properties
	a_sel_not_both: assert property (!(pin_level[PIN_SEL_CTRL] && pin_level[PIN_SEL_LOGIC]))
		else $error("both flash selects high");
	a_sel_quiet_video: assert property (pin_level[PIN_BUF_EN] |->
		!pin_level[PIN_SEL_CTRL] && !pin_level[PIN_SEL_LOGIC]) else $error("select high in video");
	a_sel_flash_only: assert property (!host_oe_n[PIN_SEL_CTRL] |-> s_flash_cfg)
		else $error("controller select driven outside flash setup");
	a_one_select: assert property (!host_oe_n[PIN_SEL_CTRL] |-> host_oe_n[PIN_SEL_LOGIC])
		else $error("both selects driven");
	a_miso_input: assert property (s_flash_cfg |-> host_oe_n[PIN_SPI_MISO])
		else $error("host drives miso");
	a_video_inputs: assert property (!host_oe_n[PIN_BUF_EN] |-> host_oe_n[PIN_SEL_CTRL] &&
		host_oe_n[PIN_SEL_LOGIC] && host_oe_n[PIN_PWR]) else $error("video drives control lines");
	a_pwr_off_flash: assert property (pin_level[PIN_PWR] |-> s_flash_cfg)
		else $error("power off outside flash setup");
	a_pwr_drive_high: assert property (!host_oe_n[PIN_PWR] |-> host_out[PIN_PWR])
		else $error("power line driven low");
	a_change_via_inputs: assert property ((host_oe_n != $past(host_oe_n)) |->
		all_in || $past(all_in)) else $error("drive set changed without all inputs");
	a_inputs_settle: assert property (s_leave_inputs |-> in_cnt_r >= 4'h8)
		else $error("inputs phase too short");
endmodule

// ### host_mode_pin_control_test.sv
// self-checking bench: host end and board end joined through the connector
module host_mode_pin_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pin_mux_pkg::*;

	localparam int GAP = 50;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] vid_red = 8'hb7;
	logic [7:0] vid_green = 8'h5a;
	logic [7:0] vid_blue = 8'hc3;
	logic vid_de = 1'b1;
	logic vid_vsync = 1'b0;
	logic vid_hsync = 1'b1;
	logic vid_take;
	logic [7:0] flash_reply = 8'h3c;
	logic [5:0] pixel_red;
	logic [5:0] pixel_green;
	logic [5:0] pixel_blue;
	logic pixel_data_valid;
	logic pixel_vsync;
	logic pixel_hsync;
	logic i2c_scl;
	logic i2c_sda;
	logic board_power_off;
	logic flash_sel_ctrl;
	logic flash_sel_logic;
	logic [7:0] flash_byte;
	logic flash_byte_valid;
	logic select_fault;
	logic [7:0] last_byte = 8'h0;
	int byte_cnt = 0;
	int error_cnt = 0;
	int checks_done = 0;

	always #2 sys_clk = ~sys_clk;

	// ==========================================================
	// both ends and the checker
	pin_bus bus();
	host_mode_pin_control #(.I2C_GAP_CYCLES(GAP)) u_host_mode_pin_control (
		.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .vid_red(vid_red), .vid_green(vid_green),
		.vid_blue(vid_blue), .vid_de(vid_de), .vid_vsync(vid_vsync), .vid_hsync(vid_hsync),
		.vid_take(vid_take), .pins(bus));
	board_pin_receiver u_board_pin_receiver (
		.link_clk(bus.link_clk), .reset_n(reset_n), .pins(bus), .flash_reply(flash_reply),
		.pixel_red(pixel_red), .pixel_green(pixel_green), .pixel_blue(pixel_blue),
		.pixel_data_valid(pixel_data_valid), .pixel_vsync(pixel_vsync),
		.pixel_hsync(pixel_hsync), .i2c_scl(i2c_scl), .i2c_sda(i2c_sda),
		.board_power_off(board_power_off), .flash_sel_ctrl(flash_sel_ctrl),
		.flash_sel_logic(flash_sel_logic), .flash_byte(flash_byte),
		.flash_byte_valid(flash_byte_valid), .select_fault(select_fault));
	host_mode_pin_control_properties u_host_mode_pin_control_properties (
		.sys_clk(sys_clk), .reset_n(reset_n), .host_out(bus.host_out),
		.host_oe_n(bus.host_oe_n), .pin_level(bus.pin_level));

	always @(posedge bus.link_clk) begin
		if (flash_byte_valid === 1'b1) begin
			last_byte = flash_byte;
			byte_cnt++;
		end
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	// holds the request until waitrequest is seen low at a rising edge
	task automatic bus_op(input logic [2:0] a, input logic wr_n_rd, input logic [31:0] d,
		output logic [31:0] q, output int w);
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= wr_n_rd;
		avs_read <= !wr_n_rd;
		avs_writedata <= d;
		w = 0;
		do begin
			@(posedge sys_clk);
			w++;
		end while (avs_waitrequest !== 1'b0 && w < 2000);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk(32'(w < 2000), 32'h1, "bus answer");
	endtask

	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] q;
		int w;
		bus_op(a, 1'b1, d, q, w);
	endtask

	task automatic rd(input logic [2:0] a, output logic [31:0] q);
		int w;
		bus_op(a, 1'b0, 32'h0, q, w);
	endtask

	task automatic set_mode(input mode_e m);
		logic [31:0] q;
		int n;
		wr(REG_CTRL, {30'h0, m});
		n = 0;
		do begin
			rd(REG_STATUS, q);
			n++;
		end while (q[3:0] !== {2'h2, m} && n < 100);
		chk(q[7:0], {m, 2'h0, 2'h2, m}, "status after mode change");
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] q;
		chk(bus.host_oe_n, 28'hfffffff, "lines undriven after reset");
		rd(REG_STATUS, q);
		chk(q, 32'h8, "status at rest");
		wr(3'h5, 32'hffffffff);
		rd(3'h5, q);
		chk(q, 32'h0, "unmapped read");
		chk(board_power_off, 1'b0, "floating power line keeps board on");
	endtask

	task automatic t_video();
		logic [31:0] q;
		int w;
		int n;
		set_mode(MODE_VIDEO);
		n = 0;
		while (vid_take !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'(n < 20), 32'h1, "pixel taken");
		chk(bus.pin_level[PIN_BUF_EN], 1'b1, "buffer enable high");
		chk(bus.host_oe_n[23:0], 24'h0, "video and i2c lines driven");
		chk({bus.host_oe_n[PIN_SEL_LOGIC:PIN_SEL_CTRL]}, 4'hd, "selects and power undriven");
		repeat (60) @(posedge sys_clk);
		chk({pixel_red, pixel_green, pixel_blue}, {vid_red[7:2], vid_green[7:2], vid_blue[7:2]},
			"colour bits 7..2");
		chk({pixel_data_valid, pixel_vsync, pixel_hsync}, 3'h5, "enable and syncs");
		vid_de <= 1'b0;
		vid_vsync <= 1'b1;
		vid_hsync <= 1'b0;
		repeat (60) @(posedge sys_clk);
		chk({pixel_data_valid, pixel_vsync, pixel_hsync}, 3'h2, "enable and syncs follow");
		chk({flash_sel_ctrl, flash_sel_logic, board_power_off}, 3'h0, "board controls idle");
		n = byte_cnt;
		wr(REG_SPI, 32'h5a);
		rd(REG_SPI, q);
		chk(q[SPI_BUSY_BIT], 1'b0, "spi stays idle in video");
		repeat (600) @(posedge sys_clk);
		chk(byte_cnt, n, "spi byte dropped in video");
		wr(REG_I2C, 32'h7);
		rd(REG_I2C, q);
		chk(q[2], 1'b1, "command gap busy");
		bus_op(REG_I2C, 1'b1, 32'h1, q, w);
		chk(32'(w >= GAP - 8 && w <= GAP + 8), 32'h1, "command gap length");
		repeat (60) @(posedge sys_clk);
		chk({i2c_scl, i2c_sda}, 2'h2, "i2c lines follow register");
	endtask

	task automatic t_flash(input mode_e m, input int sp, input int op, input logic [7:0] b);
		logic [31:0] q;
		int n;
		set_mode(m);
		chk(bus.pin_level[sp], 1'b1, "chosen select high");
		chk(bus.host_oe_n[op], 1'b1, "other select undriven");
		chk(bus.host_oe_n[PIN_BUF_EN], 1'b1, "buffer enable floating");
		chk({bus.host_oe_n[PIN_PWR], bus.pin_level[PIN_PWR]}, 2'h1, "power line driven high");
		chk({bus.host_oe_n[PIN_SPI_MISO], bus.host_oe_n[PIN_SDA]}, 2'h3, "miso, i2c undriven");
		repeat (60) @(posedge sys_clk);
		chk(board_power_off, 1'b1, "board turned off");
		chk(select_fault, 1'b0, "no select fault at the board");
		chk({flash_sel_ctrl, flash_sel_logic}, {m == MODE_CTRL_FLASH, m == MODE_LOGIC_FLASH},
			"board sees one select");
		n = byte_cnt;
		wr(REG_SPI, {24'h0, b});
		n = n + 1;
		do begin
			rd(REG_SPI, q);
		end while (q[SPI_BUSY_BIT] !== 1'b0 && checks_done < 5000);
		repeat (60) @(posedge sys_clk);
		chk(byte_cnt, n, "one byte at the flash");
		chk(last_byte, b, "byte at the flash");
		rd(REG_SPI, q);
		chk(q[7:0], flash_reply, "byte from the flash");
		chk(bus.pin_level[PIN_SPI_CS], 1'b1, "chip select released");
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset();
		t_video();
		t_flash(MODE_CTRL_FLASH, PIN_SEL_CTRL, PIN_SEL_LOGIC, 8'ha5);
		t_flash(MODE_LOGIC_FLASH, PIN_SEL_LOGIC, PIN_SEL_CTRL, 8'h96);
		set_mode(MODE_VIDEO);
		set_mode(MODE_NONE);
		chk(bus.host_oe_n, 28'hfffffff, "all lines released");
		end_of_test();
	end

	initial begin
		#200000;
		error_cnt++;
		end_of_test();
	end
endmodule
